// ===== logic/rm_pkg.sv
// constants and types for the real-mode address and stack unit
// assumes a single core clock and an active-low asynchronous reset
package rm_pkg;
  localparam int unsigned SEG_SHIFT = 4;
  localparam int unsigned PA_W = 21;
  localparam logic [31:0] OFS_LIMIT = 32'h0000FFFF;
  localparam logic [7:0] VEC_STACK_FAULT = 8'h0C;
  localparam logic [7:0] VEC_GP_FAULT = 8'h0D;
  localparam logic [31:0] TBL_BASE_RST = 32'h00000000;
  localparam logic [15:0] TBL_LIMIT_RST = 16'h03FF;
  localparam int unsigned TBL_ENTRY_SHIFT = 2;
  localparam int unsigned IF_BIT = 9;
  localparam int unsigned TF_BIT = 8;
  localparam int unsigned RF_BIT = 16;
  localparam int unsigned AC_BIT = 18;
  localparam logic [31:0] FLAGS_RST = 32'h00000002;
  localparam logic [31:0] IP_RST = 32'h0000FFF0;
  localparam logic [15:0] CS_RST = 16'hF000;
  localparam logic [15:0] SS_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] WORD_BYTES = 16'h0002;

  typedef enum logic [5:0] {
    CMD_NONE = 6'h01,
    CMD_CALL = 6'h02,
    CMD_RET = 6'h04,
    CMD_INT = 6'h08,
    CMD_INTERRUPT_RETURN_INSTR = 6'h10,
    CMD_LDTBL = 6'h20
  } cmd_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PUSH = 7'h02,
    ST_POP = 7'h04,
    ST_VRD_OFS = 7'h08,
    ST_VRD_SEG = 7'h10,
    ST_WAIT = 7'h20,
    ST_DONE = 7'h40
  } state_t;
endpackage

// ===== logic/rm_mem_if.sv
// memory request carrier between the sequencer and the address former
// assumes one request at a time, answered by the address former
`timescale 1ns/100ps
interface rm_mem_if;
  import rm_pkg::*;
  logic [15:0] seg;
  logic [31:0] ofs;
  logic wide_ofs;
  logic [PA_W-1:0] phys;
  logic fault;
  modport req (output seg, output ofs, output wide_ofs, input phys, input fault);
  modport fmt (input seg, input ofs, input wide_ofs, output phys, output fault);
endinterface

// ===== logic/rm_addr_former.sv
// combinational real-mode address former
// assumes the mask input has already been synchronised
`timescale 1ns/100ps
module rm_addr_former
  import rm_pkg::*;
(
  rm_mem_if.fmt m,
  input wire logic a20_mask_n
);
  logic [PA_W-1:0] sum;
  // selector used directly as base, no table lookup; 21-bit sum keeps carry
  assign sum = {1'b0, m.seg, 4'h0} + PA_W'(m.ofs[15:0]);
  assign m.phys = {sum[PA_W-1] & a20_mask_n, sum[PA_W-2:0]};
  assign m.fault = m.wide_ofs && (m.ofs > OFS_LIMIT);
endmodule

// ===== logic/rm_unit.sv
// real-mode address and stack sequencer with data-operand address path
// assumes a word-wide memory that answers each request with mem_ack
`timescale 1ns/100ps
// Functional notes
// - reset starts core in real-address mode
// - selectors are bases, never table indexes
// - base is selector shifted left four
// - carry above 1 MByte kept
// - active-low mask forces A20 low
// - segments 64K, 16-bit offsets
// - wide offset above FFFFH faults, vector 13
// - short pointer is low half of 32-bit
// - 16-bit flags are low half of 32-bit
// - stack grows down in stack segment
// - far call pushes CS then IP, near call IP only; return pops
// - interrupt pushes flags, CS, IP; return pops
// - table of 4-byte pointers by vector
// - table base relocatable by load instruction
// - operand prefix selects 32-bit data forms
// - address prefix allows 32-bit offsets, checked
// - floating-point unit stays enabled
// - table reset base zero, limit 3FFH
// - interrupt entry clears interrupt-enable flag
module rm_unit
  import rm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic addr_bit20_mask_n,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  input wire logic far_sel,
  input wire logic [7:0] vector,
  input wire logic [31:0] target_ofs,
  input wire logic [15:0] target_seg,
  input wire logic [31:0] tbl_base_in,
  input wire logic [15:0] tbl_limit_in,
  input wire logic dat_valid,
  input wire logic [15:0] dat_seg,
  input wire logic [31:0] dat_ofs,
  input wire logic addr_prefix,
  input wire logic opnd_prefix,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic busy_ff,
  output logic done_ff,
  output logic real_mode_ff,
  output logic fpu_enable_ff,
  output logic wide_opnd_ff,
  output logic fault_ff,
  output logic [7:0] fault_vec_ff,
  output logic mem_req_ff,
  output logic mem_we_ff,
  output logic [PA_W-1:0] mem_addr_ff,
  output logic [15:0] mem_wdata_ff,
  output logic dat_addr_valid_ff,
  output logic [PA_W-1:0] dat_addr_ff,
  output logic [31:0] extended_instr_pointer_ff,
  output logic [15:0] cs_ff,
  output logic [31:0] extended_flags_reg_ff,
  output logic [15:0] stack_pointer_reg_ff,
  output logic [31:0] tbl_base_ff,
  output logic [15:0] tbl_limit_ff
);

  ////////////////////////////////////////////////////////////////////////
  // mask pin synchroniser
  logic [2:0] a20_sync_ff;
  logic a20_mask_n_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      a20_sync_ff <= 3'h7;
    end
    else
    begin
      a20_sync_ff <= {a20_sync_ff[1:0], addr_bit20_mask_n};
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      a20_mask_n_ff <= 1'b1;
    end
    else if (a20_sync_ff[1] == a20_sync_ff[2])
    begin
      a20_mask_n_ff <= a20_sync_ff[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address formers
  rm_mem_if stk_if();
  rm_mem_if dat_if();

  rm_addr_former u_stk_fmt (
    .m(stk_if.fmt),
    .a20_mask_n(a20_mask_n_ff)
  );
  rm_addr_former u_dat_fmt (
    .m(dat_if.fmt),
    .a20_mask_n(a20_mask_n_ff)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  state_t state_ff;
  state_t nxt_state;
  cmd_t op_ff;
  logic far_ff;
  logic [1:0] cnt_ff;
  logic [15:0] ss_ff;
  logic [15:0] vseg_ff;
  logic [15:0] vofs_ff;
  logic [15:0] pop_ip_ff;
  logic [15:0] pop_cs_ff;
  logic [1:0] nwords;
  logic [15:0] push_word;
  logic [15:0] vec_ofs;

  function automatic logic [1:0] words_of(input cmd_t c, input logic f);
    words_of = 2'd1;
    if (c == CMD_INT || c == CMD_INTERRUPT_RETURN_INSTR)
    begin
      words_of = 2'd3;
    end
    else if (f)
    begin
      words_of = 2'd2;
    end
  endfunction

  assign nwords = words_of(op_ff, far_ff);
  assign vec_ofs = {6'h00, vector, 2'b00};

  // push order: flags (int only), CS (far/int), then IP
  always_comb
  begin
    push_word = extended_instr_pointer_ff[15:0];
    if (cnt_ff == 2'd2)
    begin
      push_word = extended_flags_reg_ff[15:0];
    end
    else if (cnt_ff == 2'd1)
    begin
      push_word = cs_ff;
    end
  end

  assign stk_if.seg = (state_ff == ST_VRD_OFS || state_ff == ST_VRD_SEG) ? 16'h0000 : ss_ff;
  assign stk_if.wide_ofs = 1'b0;
  always_comb
  begin
    stk_if.ofs = {16'h0000, stack_pointer_reg_ff - WORD_BYTES};
    if (state_ff == ST_POP)
    begin
      stk_if.ofs = {16'h0000, stack_pointer_reg_ff};
    end
    else if (state_ff == ST_VRD_OFS)
    begin
      stk_if.ofs = tbl_base_ff + 32'(vec_ofs);
    end
    else if (state_ff == ST_VRD_SEG)
    begin
      stk_if.ofs = tbl_base_ff + 32'(vec_ofs) + 32'd2;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (cmd_valid && (cmd == CMD_CALL || cmd == CMD_INT))
        begin
          nxt_state = ST_PUSH;
        end
        else if (cmd_valid && (cmd == CMD_RET || cmd == CMD_INTERRUPT_RETURN_INSTR))
        begin
          nxt_state = ST_POP;
        end
        else if (cmd_valid && cmd == CMD_LDTBL)
        begin
          nxt_state = ST_DONE;
        end
      end
      ST_PUSH:
      begin
        if (mem_ack && cnt_ff == 2'd0)
        begin
          nxt_state = (op_ff == CMD_INT) ? ST_VRD_OFS : ST_DONE;
        end
      end
      ST_POP:
      begin
        if (mem_ack && cnt_ff == nwords - 2'd1)
        begin
          nxt_state = ST_DONE;
        end
      end
      ST_VRD_OFS:
      begin
        if (mem_ack)
        begin
          nxt_state = ST_VRD_SEG;
        end
      end
      ST_VRD_SEG:
      begin
        if (mem_ack)
        begin
          nxt_state = ST_DONE;
        end
      end
      ST_WAIT:
      begin
        nxt_state = ST_DONE;
      end
      ST_DONE:
      begin
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // command capture and word counter
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_ff <= CMD_NONE;
      far_ff <= 1'b0;
      cnt_ff <= 2'd0;
    end
    else if (state_ff == ST_IDLE && cmd_valid)
    begin
      op_ff <= cmd;
      far_ff <= far_sel;
      cnt_ff <= (cmd == CMD_INT) ? 2'd2 : ((cmd == CMD_CALL && far_sel) ? 2'd1 : 2'd0);
      if (cmd == CMD_RET || cmd == CMD_INTERRUPT_RETURN_INSTR)
      begin
        cnt_ff <= 2'd0;
      end
    end
    else if (mem_ack && state_ff == ST_PUSH && cnt_ff != 2'd0)
    begin
      cnt_ff <= cnt_ff - 2'd1;
    end
    else if (mem_ack && state_ff == ST_POP)
    begin
      cnt_ff <= cnt_ff + 2'd1;
    end
  end

  // memory request port
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= '0;
      mem_wdata_ff <= 16'h0000;
    end
    else
    begin
      // raised only from a settled state, so address, data and write flag go out with it
      mem_req_ff <= (state_ff == ST_PUSH || state_ff == ST_POP || state_ff == ST_VRD_OFS
        || state_ff == ST_VRD_SEG) && !mem_ack;
      mem_we_ff <= (state_ff == ST_PUSH);
      mem_addr_ff <= stk_if.phys;
      mem_wdata_ff <= push_word;
    end
  end

  // stack pointer and stack segment
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stack_pointer_reg_ff <= SP_RST;
      ss_ff <= SS_RST;
    end
    else if (mem_ack && state_ff == ST_PUSH)
    begin
      stack_pointer_reg_ff <= stack_pointer_reg_ff - WORD_BYTES;
    end
    else if (mem_ack && state_ff == ST_POP)
    begin
      stack_pointer_reg_ff <= stack_pointer_reg_ff + WORD_BYTES;
    end
  end

  // popped words: IP, then CS, then flags
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pop_ip_ff <= 16'h0000;
      pop_cs_ff <= 16'h0000;
      vofs_ff <= 16'h0000;
      vseg_ff <= 16'h0000;
    end
    else if (mem_ack)
    begin
      if (state_ff == ST_POP && cnt_ff == 2'd0)
      begin
        pop_ip_ff <= mem_rdata;
      end
      if (state_ff == ST_POP && cnt_ff == 2'd1)
      begin
        pop_cs_ff <= mem_rdata;
      end
      if (state_ff == ST_VRD_OFS)
      begin
        vofs_ff <= mem_rdata;
      end
      if (state_ff == ST_VRD_SEG)
      begin
        vseg_ff <= mem_rdata;
      end
    end
  end

  // instruction pointer and code segment
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      extended_instr_pointer_ff <= IP_RST;
      cs_ff <= CS_RST;
    end
    else if (state_ff == ST_DONE)
    begin
      if (op_ff == CMD_CALL)
      begin
        extended_instr_pointer_ff <= target_ofs;
        if (far_ff)
        begin
          cs_ff <= target_seg;
        end
      end
      else if (op_ff == CMD_RET || op_ff == CMD_INTERRUPT_RETURN_INSTR)
      begin
        extended_instr_pointer_ff <= {extended_instr_pointer_ff[31:16], pop_ip_ff};
        if (far_ff || op_ff == CMD_INTERRUPT_RETURN_INSTR)
        begin
          cs_ff <= pop_cs_ff;
        end
      end
      else if (op_ff == CMD_INT)
      begin
        extended_instr_pointer_ff <= {16'h0000, vofs_ff};
        cs_ff <= vseg_ff;
      end
    end
  end

  // flags: IF, TF, RF and AC cleared on handler entry, low half restored on interrupt return
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      extended_flags_reg_ff <= FLAGS_RST;
    end
    else if (state_ff == ST_POP && mem_ack && op_ff == CMD_INTERRUPT_RETURN_INSTR && cnt_ff == 2'd2)
    begin
      extended_flags_reg_ff <= {extended_flags_reg_ff[31:16], mem_rdata};
    end
    else if (state_ff == ST_VRD_OFS && mem_ack)
    begin
      extended_flags_reg_ff[IF_BIT] <= 1'b0;
      extended_flags_reg_ff[TF_BIT] <= 1'b0;
      extended_flags_reg_ff[RF_BIT] <= 1'b0;
      extended_flags_reg_ff[AC_BIT] <= 1'b0;
    end
  end

  // interrupt table register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tbl_base_ff <= TBL_BASE_RST;
      tbl_limit_ff <= TBL_LIMIT_RST;
    end
    else if (state_ff == ST_IDLE && cmd_valid && cmd == CMD_LDTBL)
    begin
      tbl_base_ff <= tbl_base_in;
      tbl_limit_ff <= tbl_limit_in;
    end
  end

  // mode, status and data-operand address path
  assign dat_if.seg = dat_seg;
  assign dat_if.ofs = dat_ofs;
  assign dat_if.wide_ofs = addr_prefix;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      real_mode_ff <= 1'b1;
      fpu_enable_ff <= 1'b1;
      wide_opnd_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
      fault_vec_ff <= 8'h00;
      dat_addr_valid_ff <= 1'b0;
      dat_addr_ff <= '0;
    end
    else
    begin
      wide_opnd_ff <= opnd_prefix;
      busy_ff <= (nxt_state != ST_IDLE);
      done_ff <= (state_ff == ST_DONE);
      fault_ff <= dat_valid && dat_if.fault;
      fault_vec_ff <= (dat_valid && dat_if.fault) ? VEC_GP_FAULT : 8'h00;
      dat_addr_valid_ff <= dat_valid && !dat_if.fault;
      dat_addr_ff <= dat_if.phys;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_reset_mode: assert property (@(posedge clk) disable iff (!arst_n)
    real_mode_ff && fpu_enable_ff) else $error("left real mode");
  a_fault_no_access: assert property (@(posedge clk) disable iff (!arst_n)
    dat_valid && addr_prefix && dat_ofs > OFS_LIMIT |=> fault_ff && !dat_addr_valid_ff)
    else $error("wide offset did not fault");
  a_addr_formed: assert property (@(posedge clk) disable iff (!arst_n)
    dat_valid && !addr_prefix && a20_mask_n_ff |=> dat_addr_ff ==
    ({1'b0, $past(dat_seg), 4'h0} + {5'h00, $past(dat_ofs[15:0])}))
    else $error("bad physical address");
  a_a20_masked: assert property (@(posedge clk) disable iff (!arst_n)
    !a20_mask_n_ff && $stable(a20_mask_n_ff) |=> !dat_addr_ff[20])
    else $error("A20 not masked");
  a_push_down: assert property (@(posedge clk) disable iff (!arst_n)
    state_ff == ST_PUSH && mem_ack |=> stack_pointer_reg_ff ==
    $past(stack_pointer_reg_ff) - WORD_BYTES) else $error("push did not decrement");
  a_int_if_clear: assert property (@(posedge clk) disable iff (!arst_n)
    state_ff == ST_DONE && op_ff == CMD_INT |-> !extended_flags_reg_ff[IF_BIT])
    else $error("IF set in handler");
  a_int_three_push: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_valid && state_ff == ST_IDLE && cmd == CMD_INT |=> cnt_ff == 2'd2)
    else $error("interrupt push count");
  a_tbl_load: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_valid && state_ff == ST_IDLE && cmd == CMD_LDTBL |=> tbl_base_ff == $past(tbl_base_in))
    else $error("table not relocated");
  a_done_bound: assert property (@(posedge clk) disable iff (!arst_n)
    state_ff == ST_DONE |=> state_ff == ST_IDLE ##0 done_ff)
    else $error("done not reported");

  c_call: cover property (@(posedge clk) state_ff == ST_DONE && op_ff == CMD_CALL);
  c_int: cover property (@(posedge clk) state_ff == ST_DONE && op_ff == CMD_INT);
  c_interrupt_return_instr: cover property (@(posedge clk) state_ff == ST_DONE && op_ff == CMD_INTERRUPT_RETURN_INSTR);
  c_fault: cover property (@(posedge clk) fault_ff);
endmodule

// ===== verification/rm_mem_model.sv
// system memory partner: 16-bit words keyed by byte address, one ack per request
// assumes the unit holds each request steady until it is acknowledged
`timescale 1ns/100ps
module rm_mem_model
  import rm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [PA_W-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [3:0] lag,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [int];
  logic [3:0] wait_ff;

  ////////////////////////////////////////////////////////////////////////////
  // read data toggles outside an answer so stale words never pass
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_ack <= 1'b0;
      wait_ff <= 4'h0;
      mem_rdata <= 16'hA5C3;
    end
    else if (mem_ack)
    begin
      mem_ack <= 1'b0;
      wait_ff <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end
    else if (mem_req && wait_ff >= lag)
    begin
      mem_ack <= 1'b1;
      if (mem_we)
        mem[int'(mem_addr)] = mem_wdata;
      else
        mem_rdata <= mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : ~mem_rdata;
    end
    else
    begin
      wait_ff <= wait_ff + {3'h0, mem_req};
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ===== verification/tb.sv
// self-checking bench for the real-mode address and stack unit
// assumes the memory partner model and the unit's package
`timescale 1ns/100ps
module tb;
  import rm_pkg::*;
  typedef struct packed {logic f; logic [PA_W-1:0] a;} dexp_t;
  typedef struct packed {logic [PA_W-1:0] a; logic [15:0] d;} wexp_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic mask_n = 1'b1;
  logic cmd_valid = 1'b0;
  logic far_sel = 1'b0;
  logic dat_valid = 1'b0;
  logic addr_prefix = 1'b0;
  logic opnd_prefix = 1'b0;
  logic op_prev = 1'b0;
  logic [3:0] lag = 4'h0;
  cmd_t cmd = CMD_NONE;
  logic [7:0] vector = 8'h00;
  logic [31:0] target_ofs = 32'h00000000;
  logic [31:0] tbl_base_in = 32'h00000000;
  logic [31:0] dat_ofs = 32'h00000000;
  logic [31:0] rnd = 32'h000140BA;
  logic [15:0] target_seg = 16'h0000;
  logic [15:0] tbl_limit_in = 16'h0000;
  logic [15:0] dat_seg = 16'h0000;
  logic busy_ff, done_ff, real_mode_ff, fpu_enable_ff, wide_opnd_ff, fault_ff, mem_req_ff;
  logic mem_we_ff, dat_addr_valid_ff, mem_ack;
  logic [7:0] fault_vec_ff;
  logic [PA_W-1:0] mem_addr_ff, dat_addr_ff;
  logic [15:0] mem_wdata_ff, cs_ff, stack_pointer_reg_ff, tbl_limit_ff, mem_rdata;
  logic [31:0] extended_instr_pointer_ff, extended_flags_reg_ff, tbl_base_ff;
  int errors = 0;
  int n_checks = 0;
  dexp_t dq[$];
  wexp_t wq[$];

  always #5 clk = ~clk;

  rm_unit dut (.clk, .arst_n, .addr_bit20_mask_n(mask_n), .cmd_valid, .cmd, .far_sel,
    .vector, .target_ofs, .target_seg, .tbl_base_in, .tbl_limit_in, .dat_valid,
    .dat_seg, .dat_ofs, .addr_prefix, .opnd_prefix, .mem_ack, .mem_rdata, .busy_ff,
    .done_ff, .real_mode_ff, .fpu_enable_ff, .wide_opnd_ff, .fault_ff, .fault_vec_ff,
    .mem_req_ff, .mem_we_ff, .mem_addr_ff, .mem_wdata_ff, .dat_addr_valid_ff,
    .dat_addr_ff, .extended_instr_pointer_ff, .cs_ff, .extended_flags_reg_ff,
    .stack_pointer_reg_ff, .tbl_base_ff, .tbl_limit_ff);

  rm_mem_model mdl (.clk, .arst_n, .mem_req(mem_req_ff), .mem_we(mem_we_ff),
    .mem_addr(mem_addr_ff), .mem_wdata(mem_wdata_ff), .lag, .mem_ack, .mem_rdata);

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic give_verdict;
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic wr(input logic [PA_W-1:0] a, input logic [15:0] d);
    wq.push_back({a, d});
  endtask

  task automatic regs(input logic [31:0] i, input logic [15:0] c, s, input logic [31:0] f);
    check(extended_instr_pointer_ff === i, "instruction pointer");
    check(cs_ff === c, "code segment");
    check(stack_pointer_reg_ff === s, "stack offset");
    check(extended_flags_reg_ff === f, "flags");
  endtask

  task automatic do_cmd(input cmd_t c, input logic f, input logic [7:0] v,
    input logic [31:0] o, input logic [15:0] s);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    far_sel <= f;
    vector <= v;
    target_ofs <= o;
    target_seg <= s;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    check(busy_ff === 1'b1, "not busy after command");
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk);
      #1;
      if (done_ff === 1'b1)
        break;
    end
    if (i == 200)
    begin
      check(1'b0, "no completion");
      give_verdict();
    end
    check(busy_ff === 1'b0, "busy after completion");
  endtask

  task automatic dat(input logic [15:0] s, input logic [31:0] o, input logic p);
    logic [PA_W-1:0] a;
    a = {1'b0, s, 4'h0} + {5'h00, o[15:0]};
    a[20] = a[20] & mask_n;
    @(posedge clk);
    dat_valid <= 1'b1;
    dat_seg <= s;
    dat_ofs <= o;
    addr_prefix <= p;
    opnd_prefix <= rnd[3];
    dq.push_back({p && (o > OFS_LIMIT), a});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // result watcher: oldest note against each answer
  always @(posedge clk)
  begin
    dexp_t e;
    wexp_t x;
    if (arst_n)
    begin
      check(wide_opnd_ff === op_prev, "operand width");
      op_prev <= opnd_prefix;
      if (dat_addr_valid_ff === 1'b1 || fault_ff === 1'b1)
      begin
        e = dq.pop_front();
        check(fault_ff === e.f, "fault flag");
        check(fault_vec_ff === (e.f ? VEC_GP_FAULT : 8'h00), "fault vector");
        check(dat_addr_valid_ff === !e.f, "access despite fault");
        if (!e.f)
          check(dat_addr_valid_ff === 1'b1 && dat_addr_ff === e.a, "data addr");
      end
      if (mem_req_ff === 1'b1 && mem_we_ff === 1'b1 && mem_ack === 1'b1)
      begin
        x = wq.pop_front();
        check(mem_addr_ff === x.a && mem_wdata_ff === x.d, "stack write");
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    regs(IP_RST, CS_RST, SP_RST, FLAGS_RST); // reset state
    check(real_mode_ff === 1'b1 && fpu_enable_ff === 1'b1, "mode"); // reset mode
    check(tbl_base_ff === 32'h0 && tbl_limit_ff === 16'h03FF, "table"); // reset table
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      mask_n <= (m == 0); // wrap mask
      repeat (8) @(posedge clk);
      dat(16'hFFFF, 32'h0000FFFF, 1'b0); // carry kept or masked
      dat(16'hFFFF, 32'h0000FFFF, 1'b1); // prefix in range
      dat(16'hFFFF, 32'h00010000, 1'b1); // just above limit
      for (int k = 0; k < 40; k++)
      begin
        repeat (16) rnd = lfsr(rnd);
        dat(rnd[31:16], rnd[1] ? {rnd[15:0], rnd[31:16]} : {16'h0000, rnd[23:8]}, rnd[0]);
      end
      @(posedge clk);
      dat_valid <= 1'b0;
    end
    wr(21'h0FFFE, 16'hFFF0);
    do_cmd(CMD_CALL, 1'b0, 8'h00, 32'h00000100, 16'h0000);
    regs(32'h00000100, 16'hF000, 16'hFFFE, 32'h2); // near call
    lag <= 4'h3;
    wr(21'h0FFFC, 16'hF000);
    wr(21'h0FFFA, 16'h0100);
    do_cmd(CMD_CALL, 1'b1, 8'h00, 32'h00000200, 16'h1000);
    regs(32'h00000200, 16'h1000, 16'hFFFA, 32'h2); // far call
    do_cmd(CMD_RET, 1'b1, 8'h00, 32'h0, 16'h0);
    regs(32'h00000100, 16'hF000, 16'hFFFE, 32'h2); // far return
    do_cmd(CMD_RET, 1'b0, 8'h00, 32'h0, 16'h0);
    regs(32'h0000FFF0, 16'hF000, 16'h0000, 32'h2); // near return
    mdl.mem[32'h84] = 16'h1234;
    mdl.mem[32'h86] = 16'h5678;
    mdl.mem[32'h7FC] = 16'hABCD;
    mdl.mem[32'h7FE] = 16'h2468;
    wr(21'h0FFFE, 16'h0002);
    wr(21'h0FFFC, 16'hF000);
    wr(21'h0FFFA, 16'hFFF0);
    do_cmd(CMD_INT, 1'b0, 8'h21, 32'h0, 16'h0);
    regs(32'h00001234, 16'h5678, 16'hFFFA, 32'h2); // handler entry
    mdl.mem[32'h0FFFE] = 16'h0302;
    do_cmd(CMD_INTERRUPT_RETURN_INSTR, 1'b0, 8'h00, 32'h0, 16'h0);
    regs(32'h0000FFF0, 16'hF000, 16'h0000, 32'h00000302); // handler return
    lag <= 4'h0;
    tbl_base_in <= 32'h00000400;
    tbl_limit_in <= 16'h07FF;
    do_cmd(CMD_LDTBL, 1'b0, 8'h00, 32'h0, 16'h0);
    check(tbl_base_ff === 32'h400 && tbl_limit_ff === 16'h07FF, "table load");
    wr(21'h0FFFE, 16'h0302);
    wr(21'h0FFFC, 16'hF000);
    wr(21'h0FFFA, 16'hFFF0);
    do_cmd(CMD_INT, 1'b0, 8'hFF, 32'h0, 16'h0);
    regs(32'h0000ABCD, 16'h2468, 16'hFFFA, 32'h2); // moved table, IF and TF cleared
    check(real_mode_ff === 1'b1 && fpu_enable_ff === 1'b1, "mode held");
    repeat (4) @(posedge clk);
    check(dq.size() == 0 && wq.size() == 0, "missing answers");
    give_verdict();
  end
endmodule
